// file: hw/cart_polar_conv.sv
`timescale 1ns/1ns
module cart_polar_conv
  import cart_polar_pkg::*;
#(
  parameter int ITERATIONS = ITER_N
)(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  // Configuration
  input  wire conv_cfg_t         cfg_in,
  // Gain-scaled or resampled samples
  input  wire logic [GAIN_W-1:0] gain_i_in,
  input  wire logic [GAIN_W-1:0] gain_q_in,
  input  wire logic              gain_rdy_in,
  input  wire logic              resamp_rdy_in,
  // Direct FIR samples, captured on the gain-stage or resampler strobe, as resamp_on picks
  input  wire logic [FIR_W-1:0]  fir_i_in,
  input  wire logic [FIR_W-1:0]  fir_q_in,
  // Results
  output conv_res_t              res_out,
  output logic                   res_valid_out,
  output logic [ITER_N-1:0]      iter_done_out
);

  // Elaboration check: the step counter and angle table stop at the full count
  if (ITERATIONS < 1 || ITERATIONS > ITER_N)
  begin
    $error("ITERATIONS must lie in 1..17");
  end

  // Arctangent table, 2^-k radians scaled to a full turn of 2^PH_ACC_W
  function automatic logic [PH_ACC_W-1:0] atan_turn(input int k);
    real a;
    a = $atan(1.0 / (2.0 ** k)) / (2.0 * 3.14159265358979) * (2.0 ** PH_ACC_W);
    return PH_ACC_W'($rtoi(a));
  endfunction

  // Left half-plane vectors are flipped first; the rotator only converges
  // within about 100 degrees of the x axis, so this keeps every quadrant safe.
  localparam logic [PH_ACC_W-1:0] HALF_TURN = PH_ACC_W'(1) << (PH_ACC_W - 1);

  // Controller and rotator registers
  conv_state_t              state_q;
  logic signed [ACC_W-1:0]  x_q;
  logic signed [ACC_W-1:0]  y_q;
  logic [PH_ACC_W-1:0]      z_q;
  logic [4:0]               step_q;
  // Combinational helpers
  logic                     gate;
  logic signed [ACC_W-1:0]  in_i;
  logic signed [ACC_W-1:0]  in_q;
  logic signed [ACC_W-1:0]  x_sh;
  logic signed [ACC_W-1:0]  y_sh;
  logic [PH_ACC_W-1:0]      atan_k;
  logic signed [ACC_W-1:0]  x_step;
  logic signed [ACC_W-1:0]  y_step;
  logic [PH_ACC_W-1:0]      z_step;
  // Holding register inputs
  logic signed [ACC_W-1:0]  x_res;
  logic [PH_ACC_W-1:0]      z_res;
  conv_res_t                res_d;

  // Either ready strobe gates a sample; the resampler setting picks which
  assign gate = cfg_in.resamp_on ? resamp_rdy_in : gain_rdy_in;

  // Input alignment: both sources land with the binary point at the FIR top.
  // The direct path carries no gain stage; timing offsets with the resampler
  // are accepted as they come, the configurer is expected to bypass it.
  always_comb
  begin
    if (cfg_in.direct_fir)
    begin
      in_i = ACC_W'($signed(fir_i_in));
      in_q = ACC_W'($signed(fir_q_in));
    end
    else
    begin
      in_i = ACC_W'($signed({gain_i_in, {(FIR_W-GAIN_W){1'b0}}}));
      in_q = ACC_W'($signed({gain_q_in, {(FIR_W-GAIN_W){1'b0}}}));
    end
    // Q forced to zero last so it overrides either source
    if (cfg_in.zero_quad)
      in_q = '0;
  end

  // Per-step shift and angle, chosen by step number
  always_comb
  begin
    x_sh   = x_q >>> step_q;
    y_sh   = y_q >>> step_q;
    atan_k = '0;
    for (int k = 0; k < ITER_N; k++)
      if (step_q == 5'(k))
        atan_k = atan_turn(k);
  end

  // One refinement, driving y toward zero. Kept combinational so the holding
  // register can take the last step's outcome on the same edge that makes it.
  always_comb
  begin
    if (y_q < 0)
    begin
      x_step = x_q - y_sh;
      y_step = y_q + x_sh;
      z_step = z_q - atan_k;
    end
    else
    begin
      x_step = x_q + y_sh;
      y_step = y_q - x_sh;
      z_step = z_q + atan_k;
    end
  end

  // Controller: a new sample always restarts, even mid-iteration
  // Strobes in idle just start a run; nothing is latched until it ends
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_IDLE;
      step_q  <= '0;
    end
    else if (gate)
    begin
      state_q <= ST_RUN;
      step_q  <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_RUN:
        begin
          step_q <= step_q + 5'd1;
          if (step_q == 5'(ITERATIONS - 1))
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Vectoring rotator; pre-rotate left half-plane by a half turn
  // A gated sample always reloads, whatever step is running
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      x_q <= '0;
      y_q <= '0;
      z_q <= '0;
    end
    else if (gate)
    begin
      if (in_i < 0)
      begin
        x_q <= -in_i;
        y_q <= -in_q;
        z_q <= HALF_TURN;
      end
      else
      begin
        x_q <= in_i;
        y_q <= in_q;
        z_q <= '0;
      end
    end
    else if (state_q == ST_RUN)
    begin
      x_q <= x_step;
      y_q <= y_step;
      z_q <= z_step;
    end
  end

  // Result source: an early sample takes what has been refined so far, the
  // last step takes its own outcome so a full run really holds every step.
  always_comb
  begin
    if (gate)
    begin
      x_res = x_q;
      z_res = z_q;
    end
    else
    begin
      x_res = x_step;
      z_res = z_step;
    end
    // Magnitude LSB 2^-13 with input full scale at 1.0, so bit 15 weighs 4;
    // the largest vector with gain is about 2.33, so that bit reads zero.
    res_d.mag        = x_res[FIR_W+1 -: OUT_W];
    res_d.phase_fmt  = z_res[PH_ACC_W-1 -: OUT_W];
    res_d.phase_disc = z_res[PH_ACC_W-1 -: PHASE_W];
  end

  // Holding register: catches the full result at the end, or the partial one
  // on an early sample, so higher rates cost resolution only.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      res_out       <= '0;
      res_valid_out <= 1'b0;
      iter_done_out <= '0;
    end
    else
    begin
      res_valid_out <= 1'b0;
      if ((state_q == ST_RUN) && (gate || step_q == 5'(ITERATIONS - 1)))
      begin
        // One-cycle valid marks each latch for both downstream stages
        res_out            <= res_d;
        res_valid_out      <= 1'b1;
        iter_done_out      <= ITER_N'(step_q) + ITER_N'(gate ? 0 : 1);
      end
    end
  end

endmodule

// file: hw/cart_polar_pkg.sv
// Overview of operation
// - Take 18-bit I and Q after gain stage
// - 18-bit truncated phase; 16 to formatter, 18 to discriminator
// - Phase reads as signed or unsigned turn fraction
// - Phase bit 15 is 180, bit 14 is 90 degrees
// - Magnitude unsigned, gain 1.64676, range to 2.32
// - Magnitude MSB always zero, LSB weighs 2^-13
// - Full result after 17 clocks, then held
// - Early new sample latches partial result
// - Source select bit picks direct FIR path
// - Direct path uses all 26 FIR bits
// - Discriminator still gets top 18 phase bits
// - Direct path skips gain stage entirely
// - Gain-stage ready strobe gates input, resampler bypassed
// - Resampler ready strobe gates input when enabled
// - Direct path with resampling may misalign samples
// - Quadrature zero bit forces Q input to zero
// - Magnitude and phase aligned, one sample late
package cart_polar_pkg;

  localparam int GAIN_W   = 18;
  localparam int FIR_W    = 26;
  localparam int PHASE_W  = 18;
  localparam int OUT_W    = 16;
  localparam int ITER_N   = 17;
  // Internal guard bits above the widest input, for growth of 1.65 and sign
  localparam int GUARD_W  = 2;
  localparam int ACC_W    = FIR_W + GUARD_W + 1;
  // Extra phase fraction bits kept inside the rotator
  localparam int PH_EXT   = 6;
  localparam int PH_ACC_W = PHASE_W + PH_EXT;

  // Converter configuration
  typedef struct packed {
    logic direct_fir;   // Take the FIR output directly
    logic zero_quad;    // Force quadrature input to zero
    logic resamp_on;    // Resampler in the path
  } conv_cfg_t;

  // Converter results
  typedef struct packed {
    logic [OUT_W-1:0]   mag;
    logic [OUT_W-1:0]   phase_fmt;
    logic [PHASE_W-1:0] phase_disc;
  } conv_res_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } conv_state_t;

endpackage

// file: tb/cart_polar_asserts.sv
`timescale 1ns/1ns
module cart_polar_asserts
  import cart_polar_pkg::*;
#(
  parameter int ITERATIONS = ITER_N
)(
  // Clock and reset
  input wire logic              mclk_in,
  input wire logic              reset_in,
  // Watched ports
  input wire conv_cfg_t         cfg_in,
  input wire logic              gain_rdy_in,
  input wire logic              resamp_rdy_in,
  input wire conv_res_t         res_out,
  input wire logic              res_valid_out,
  input wire logic [ITER_N-1:0] iter_done_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic       stb;
  logic [7:0] cnt_q;
  // Edges since the taken strobe; parks past the run so idle shows
  assign stb = cfg_in.resamp_on ? resamp_rdy_in : gain_rdy_in;
  always_ff @(posedge mclk_in or posedge reset_in)
    if (reset_in) cnt_q <= 8'h00;
    else if (stb) cnt_q <= 8'h01;
    else if (cnt_q != 8'h00 && cnt_q <= ITERATIONS + 1) cnt_q <= cnt_q + 8'h01;
  sequence early_s;
    stb && cnt_q inside {[1:ITERATIONS-1]};
  endsequence
  mag_top_zero_a: assert property (!res_out.mag[15])
    else $error("magnitude top bit set");
  phase_split_a: assert property (res_out.phase_fmt == res_out.phase_disc[17:2])
    else $error("phase words disagree");
  full_run_a: assert property (cnt_q == ITERATIONS + 1 |-> res_valid_out && iter_done_out == ITERATIONS)
    else $error("full result missing");
  early_latch_a: assert property (early_s |=> res_valid_out && iter_done_out + 1 == $past(cnt_q))
    else $error("partial result not latched");
  hold_res_a: assert property (!res_valid_out |-> $stable(res_out))
    else $error("result moved without strobe");
  idle_quiet_a: assert property (cnt_q == 8'h00 || cnt_q > ITERATIONS + 1 |-> !res_valid_out)
    else $error("valid while idle");
  valid_pulse_a: assert property (res_valid_out && !stb |=> !res_valid_out)
    else $error("valid longer than one cycle");
  mid_run_quiet_a: assert property (cnt_q inside {[2:ITERATIONS]} && !$past(stb) |-> !res_valid_out)
    else $error("valid in mid run");
endmodule
bind cart_polar_conv cart_polar_asserts #(.ITERATIONS(ITERATIONS)) chk (.mclk_in, .reset_in,
  .cfg_in, .gain_rdy_in, .resamp_rdy_in, .res_out, .res_valid_out, .iter_done_out);

// file: tb/iq_source.sv
`timescale 1ns/1ns
module iq_source
  import cart_polar_pkg::*;
(
  // Clock and routing
  input  wire logic         mclk_in,
  input  wire logic         resamp_on_in,
  // Samples and strobes
  output logic [GAIN_W-1:0] gain_i_out,
  output logic [GAIN_W-1:0] gain_q_out,
  output logic              gain_rdy_out,
  output logic              resamp_rdy_out,
  output logic [FIR_W-1:0]  fir_i_out,
  output logic [FIR_W-1:0]  fir_q_out
);
  initial {gain_i_out, gain_q_out, gain_rdy_out, resamp_rdy_out, fir_i_out, fir_q_out} = '0;
  // One strobed pair; data scrambled after, as it only counts under the strobe
  task automatic put(input logic [FIR_W-1:0] i, input logic [FIR_W-1:0] q);
    @(posedge mclk_in);
    #1;
    fir_i_out = i;
    fir_q_out = q;
    // Swapped pair so a wrong source choice shows as a 90 degree error
    gain_i_out = q[25:8];
    gain_q_out = i[25:8];
    {resamp_rdy_out, gain_rdy_out} = resamp_on_in ? 2'b10 : 2'b01;
    @(posedge mclk_in);
    #1;
    {resamp_rdy_out, gain_rdy_out} = 2'b00;
    {fir_i_out, fir_q_out, gain_i_out, gain_q_out} = ~{fir_i_out, fir_q_out, gain_i_out, gain_q_out};
  endtask
endmodule

// file: tb/test_cartesian_to_polar_converter.sv
`timescale 1ns/1ns
module test_cartesian_to_polar_converter;
  import cart_polar_pkg::*;
  localparam int               iters   = 4;
  localparam logic [FIR_W-1:0] pos_x   = 26'h100_0000;
  localparam logic [FIR_W-1:0] neg_x   = 26'h300_0000;
  localparam logic [15:0]      mag_exp = 16'h1A59;
  logic              mclk_in  = 1'b0;
  logic              reset_in = 1'b1;
  conv_cfg_t         cfg      = '0;
  conv_res_t         res;
  logic              vld, gr, rr;
  logic [ITER_N-1:0] done;
  logic [GAIN_W-1:0] gi, gq;
  logic [FIR_W-1:0]  fi, fq;
  int                mismatches      = 0;
  int                samples_checked = 0;
  iq_source src (.mclk_in, .resamp_on_in(cfg.resamp_on), .gain_i_out(gi), .gain_q_out(gq),
    .gain_rdy_out(gr), .resamp_rdy_out(rr), .fir_i_out(fi), .fir_q_out(fq));
  cart_polar_conv #(.ITERATIONS(iters)) uut (.mclk_in, .reset_in, .cfg_in(cfg), .gain_i_in(gi),
    .gain_q_in(gq), .gain_rdy_in(gr), .resamp_rdy_in(rr), .fir_i_in(fi), .fir_q_in(fq),
    .res_out(res), .res_valid_out(vld), .iter_done_out(done));
  initial forever #25 mclk_in = ~mclk_in;
  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Tolerance covers the coarse angle left by the short iteration count
  task automatic chk_near(input logic [15:0] got, input logic [15:0] exp, input int tol);
    logic signed [15:0] d;
    d = got - exp;
    samples_checked++;
    if ((d <= tol && d >= -tol) !== 1'b1)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h near %h", $time, got, exp);
    end
  endtask
  task automatic meas(input int cyc, input int itr, input logic [15:0] ph);
    int c;
    c = 0;
    do
    begin
      @(posedge mclk_in);
      #1;
      c++;
    end
    while (vld !== 1'b1 && c < 40);
    chk_eq(c, cyc);
    chk_eq(done, itr);
    chk_near(res.mag, mag_exp, 48);
    chk_near(res.phase_fmt, ph, 1536);
    chk_near(res.phase_disc[17:2], ph, 1536);
  endtask
  task automatic t_paths();
    for (int d = 0; d < 2; d++)
      for (int k = 0; k < 4; k++)
      begin
        cfg = '{direct_fir: d[0], zero_quad: 1'b0, resamp_on: !d[0] && k[0]};
        src.put(k == 0 ? pos_x : k == 2 ? neg_x : '0, k == 1 ? pos_x : k == 3 ? neg_x : '0);
        meas(iters, iters, 16'((d ? k : k ^ 1) << 14));
      end
  endtask
  task automatic t_zero_quad();
    cfg = '{direct_fir: 1'b1, zero_quad: 1'b1, resamp_on: 1'b0};
    src.put(pos_x, pos_x);
    meas(iters, iters, 16'h0000);
  endtask
  task automatic t_early();
    cfg = '0;
    src.put(pos_x, '0);
    src.put(neg_x, '0);
    chk_eq(vld, 1);
    chk_eq(done, 1);
    meas(iters, iters, 16'hC000);
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    t_paths();
    t_zero_quad();
    t_early();
    give_verdict();
  end
  // Whole run needs about 82 cycles; over eighteen times that means a hang
  initial
  begin
    repeat (1500) @(posedge mclk_in);
    mismatches++;
    give_verdict();
  end
endmodule
